/* File: counter8_waveform_modes_bench.sv */
// Testbench: drives the waveform timer through its modes and checks counts, flags and waves
`timescale 1ns/1ps
module counter8_waveform_modes_bench;
  import tmw_pkg::*;

  // Design and partner connections
  logic clk, rst, compare_a_wr, compare_b_wr, wave_out_a, wave_out_b, pad_a, pad_b;
  logic [7:0] compare_wr_data, count_value, compare_a_value, compare_b_value, top, w;
  logic [1:0] dir_out, port_data;
  tmw_cfg_t cfg;
  tmw_flags_t flag_clear, flag_ack, flags;
  tmw_pin_t pin_a, pin_b;
  int n_errors, check_count, run, best;
  logic [2:0] modes [4] = '{TMW_MODE_FAST_FF, TMW_MODE_FAST_A, TMW_MODE_PC_FF, TMW_MODE_PC_A};
  logic [7:0] tops [4] = '{8'hff, 8'h10, 8'hff, 8'h10};
  int per [5] = '{1, 8, 64, 256, 1024};

  tmw_timer i_dut (.clk(clk), .rst(rst), .cfg(cfg), .compare_a_wr(compare_a_wr),
    .compare_b_wr(compare_b_wr), .compare_wr_data(compare_wr_data), .flag_clear(flag_clear),
    .flag_ack(flag_ack), .dir_out(dir_out), .port_data(port_data), .count_value(count_value),
    .compare_a_value(compare_a_value), .compare_b_value(compare_b_value), .flags(flags),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .pin_a(pin_a), .pin_b(pin_b));

  tmw_pin_load i_load (.pin_a(pin_a), .pin_b(pin_b), .pad_a(pad_a), .pad_b(pad_b));

  // 40 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare and count mismatches
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One-cycle compare write strobe, A or B
  task automatic write_cmp(input logic sel_b, input logic [7:0] d);
    compare_a_wr = ~sel_b;
    compare_b_wr = sel_b;
    compare_wr_data = d;
    @(negedge clk);
    compare_a_wr = 1'b0;
    compare_b_wr = 1'b0;
  endtask

  // One-cycle flag clear pulse, write-one or service path
  task automatic clear_flags(input logic ack);
    if (ack)
      flag_ack = 3'h7;
    else
      flag_clear = 3'h7;
    @(negedge clk);
    flag_ack = 3'h0;
    flag_clear = 3'h0;
  endtask

  // Bounded wait for a count value
  task automatic wait_count(input logic [7:0] v);
    int i;
    i = 0;
    while (count_value !== v && i < 3000)
    begin
      @(negedge clk);
      i++;
    end
    if (i >= 3000)
      check("count wait", {8'h00, count_value}, {8'h00, v});
  endtask

  // Cycles until the count next changes
  task automatic next_change(output int n);
    logic [7:0] c;
    c = count_value;
    n = 0;
    while (count_value === c && n < 2100)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  // Mode change settled by one cycle
  task automatic set_mode(input logic [2:0] m);
    cfg.wave_mode_sel = m;
    @(negedge clk);
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    final_report();
  end

  // Test sequence
  initial
  begin
    n_errors = 0;
    check_count = 0;
    rst = 1'b1;
    cfg = '0;
    compare_a_wr = 1'b0;
    compare_b_wr = 1'b0;
    compare_wr_data = 8'h00;
    flag_clear = 3'h0;
    flag_ack = 3'h0;
    dir_out = 2'h3;
    port_data = 2'h0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("reset count", 16'(count_value), 16'h0000);
    check("reset flags", 16'(flags), 16'h0000);
    check("reset wave", 16'({wave_out_a, wave_out_b}), 16'h0000);
    done("reset");

    // Compare A loaded while stopped, so the first match is the real one
    cfg.out_action_a = TMW_ACT_TOGGLE;
    write_cmp(1'b0, 8'h03);
    cfg.clk_sel = TMW_PRE_DIV1;
    set_mode(TMW_MODE_CTC);
    wait_count(8'h03);
    w = {7'h00, wave_out_a};
    @(negedge clk);
    check("clear on match", 16'(count_value), 16'h0000);
    check("flag a", 16'(flags.compare_a_flag), 16'h0001);
    @(negedge clk);
    check("toggle a", 16'(wave_out_a), {15'h0000, ~w[0]});
    check("pad a", 16'(pad_a), {15'h0000, ~w[0]});
    wait_count(8'h01);
    clear_flags(1'b0);
    check("flag a cleared", 16'(flags.compare_a_flag), 16'h0000);
    write_cmp(1'b0, 8'h80);
    wait_count(8'h60);
    write_cmp(1'b0, 8'h10);
    clear_flags(1'b1);
    wait_count(8'hff);
    @(negedge clk);
    check("wrap count", 16'(count_value), 16'h0000);
    check("overflow", 16'(flags.overflow_flag), 16'h0001);
    wait_count(8'h10);
    @(negedge clk);
    check("late match", 16'(count_value), 16'h0000);
    check("late flag", 16'(flags.compare_a_flag), 16'h0001);
    clear_flags(1'b1);
    check("flag a acked", 16'(flags.compare_a_flag), 16'h0000);
    dir_out = 2'h2;
    repeat (2) @(negedge clk);
    check("pin a released", 16'({pin_a.oe, pad_a}), 16'h0001);
    dir_out = 2'h3;
    done("clear on match");

    // Top value and top hold per PWM mode
    for (int m = 0; m < 4; m++)
    begin
      set_mode(TMW_MODE_CTC);
      write_cmp(1'b0, 8'h10);
      wait_count(8'h00);
      set_mode(modes[m]);
      clear_flags(1'b0);
      top = 8'h00;
      run = 0;
      best = 0;
      repeat (600)
      begin
        @(negedge clk);
        if (count_value > top)
          top = count_value;
        run = (count_value === tops[m]) ? run + 1 : 0;
        if (run > best)
          best = run;
      end
      check("count top", 16'(top), 16'(tops[m]));
      check("top hold", 16'(best), 16'h0001);
      check("overflow pwm", 16'(flags.overflow_flag), 16'h0001);
    end
    done("tops");

    cfg.out_action_a = TMW_ACT_CLEAR;
    set_mode(TMW_MODE_CTC);
    write_cmp(1'b0, 8'h80);
    set_mode(TMW_MODE_FAST_FF);
    wait_count(8'hff);
    wait_count(8'h50);
    check("fast set at bottom", 16'(wave_out_a), 16'h0001);
    wait_count(8'h90);
    check("fast clear on match", 16'(wave_out_a), 16'h0000);
    wait_count(8'h10);
    write_cmp(1'b0, 8'h20);
    check("buffer value", 16'(compare_a_value), 16'h0020);
    wait_count(8'h50);
    check("fast buffered", 16'(wave_out_a), 16'h0001);
    wait_count(8'h10);
    wait_count(8'h30);
    check("fast new compare", 16'(wave_out_a), 16'h0000);
    cfg.out_action_a = TMW_ACT_SET;
    wait_count(8'h10);
    check("inverting bottom", 16'(wave_out_a), 16'h0000);
    wait_count(8'h30);
    check("inverting match", 16'(wave_out_a), 16'h0001);
    done("fast");

    set_mode(TMW_MODE_CTC);
    write_cmp(1'b1, 8'h40);
    check("buffer b", 16'(compare_b_value), 16'h0040);
    cfg.out_action_a = TMW_ACT_TOGGLE;
    cfg.out_action_b = TMW_ACT_CLEAR;
    set_mode(TMW_MODE_PC_FF);
    @(negedge clk);
    w = {7'h00, wave_out_a};
    wait_count(8'hff);
    wait_count(8'h20);
    check("phase down match", 16'(wave_out_b), 16'h0001);
    check("pad b", 16'(pad_b), 16'h0001);
    wait_count(8'h80);
    check("phase up match", 16'(wave_out_b), 16'h0000);
    check("no toggle without top select", 16'(wave_out_a), 16'(w[0]));
    done("phase");

    // Tick spacing per prescaler select
    set_mode(TMW_MODE_CTC);
    write_cmp(1'b0, 8'hff);
    for (int s = 1; s < 6; s++)
    begin
      cfg.clk_sel = 3'(s);
      next_change(run);
      next_change(run);
      check("tick gap", 16'(run), 16'(per[s - 1]));
    end
    done("prescale");
    final_report();
  end
endmodule

/* File: tmw_pin_load.sv */
// Partner model: port pads with pull-ups as seen by the external load
`timescale 1ns/1ps
module tmw_pin_load
(
  // Pin drive from the timer
  input tmw_pkg::tmw_pin_t pin_a,
  input tmw_pkg::tmw_pin_t pin_b,
  // Pad levels seen by the load
  output logic pad_a,
  output logic pad_b
);
  import tmw_pkg::*;

  // A released pad floats to the pull-up level, never the last driven value
  assign pad_a = pin_a.oe ? pin_a.out : 1'b1;
  assign pad_b = pin_b.oe ? pin_b.out : 1'b1;
endmodule

/* File: tmw_pkg.sv */
// Package: modes, actions, limits and carrier types for the 8-bit waveform timer
package tmw_pkg;

  // Counter limits
  localparam logic [7:0] TMW_BOTTOM = 8'h00;
  localparam logic [7:0] TMW_MAX = 8'hff;

  // Waveform mode select values
  localparam logic [2:0] TMW_MODE_PC_FF = 3'h1;
  localparam logic [2:0] TMW_MODE_CTC = 3'h2;
  localparam logic [2:0] TMW_MODE_FAST_FF = 3'h3;
  localparam logic [2:0] TMW_MODE_PC_A = 3'h5;
  localparam logic [2:0] TMW_MODE_FAST_A = 3'h7;
  localparam int TMW_MODE_TOP_SEL_BIT = 2;

  // Compare output actions
  localparam logic [1:0] TMW_ACT_OFF = 2'h0;
  localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMW_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TMW_ACT_SET = 2'h3;

  // Prescaler selects and terminal counts (divide by N means count 0..N-1)
  localparam logic [2:0] TMW_PRE_STOP = 3'h0;
  localparam logic [2:0] TMW_PRE_DIV1 = 3'h1;
  localparam logic [2:0] TMW_PRE_DIV8 = 3'h2;
  localparam logic [2:0] TMW_PRE_DIV64 = 3'h3;
  localparam logic [2:0] TMW_PRE_DIV256 = 3'h4;
  localparam logic [2:0] TMW_PRE_DIV1024 = 3'h5;
  localparam logic [9:0] TMW_TC_DIV8 = 10'h007;
  localparam logic [9:0] TMW_TC_DIV64 = 10'h03f;
  localparam logic [9:0] TMW_TC_DIV256 = 10'h0ff;
  localparam logic [9:0] TMW_TC_DIV1024 = 10'h3ff;

  // Reset values
  localparam logic [7:0] TMW_COUNT_RST = 8'h00;
  localparam logic [7:0] TMW_COMPARE_RST = 8'h00;

  // Count direction, Gray order
  typedef enum logic {TMW_DIR_UP = 1'b0, TMW_DIR_DOWN = 1'b1} tmw_dir_t;

  // Configuration bits from the processor side
  typedef struct packed {
    logic [2:0] wave_mode_sel;
    logic [1:0] out_action_a;
    logic [1:0] out_action_b;
    logic [2:0] clk_sel;
  } tmw_cfg_t;

  // Status flags, also used for clear strobes
  typedef struct packed {
    logic overflow_flag;
    logic compare_b_flag;
    logic compare_a_flag;
  } tmw_flags_t;

  // Port pin drive, one per channel
  typedef struct packed {
    logic out;
    logic oe;
  } tmw_pin_t;

endpackage

/* File: tmw_prescale.sv */
// Prescaler: divides the system clock into the timer tick enable
`timescale 1ns/1ps
module tmw_prescale
  import tmw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Divider select
  input wire logic [2:0] clk_sel,
  // Tick enable, one clock wide
  output logic tick
);

  logic [9:0] div_count;
  logic [9:0] term;

  // Terminal count for the selected divider
  always_comb
  begin
    case (clk_sel)
      TMW_PRE_DIV8: term = TMW_TC_DIV8;
      TMW_PRE_DIV64: term = TMW_TC_DIV64;
      TMW_PRE_DIV256: term = TMW_TC_DIV256;
      TMW_PRE_DIV1024: term = TMW_TC_DIV1024;
      default: term = 10'h000;
    endcase
  end

  // Free running divider and tick
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_count <= 10'h000;
      tick <= 1'b0;
    end
    else if (clk_sel == TMW_PRE_STOP || clk_sel > TMW_PRE_DIV1024)
    begin
      div_count <= 10'h000;
      tick <= 1'b0;
    end
    else if (div_count >= term)
    begin
      div_count <= 10'h000;
      tick <= 1'b1; // RULE21
    end
    else
    begin
      div_count <= div_count + 10'h001;
      tick <= 1'b0;
    end
  end

endmodule

/* File: tmw_timer.sv */
// Top: 8-bit timer with clear-on-match, fast and phase-correct waveform modes
// Function
// RULE1: Mode 2 clears count on compare A match
// RULE2: Mode 2 late compare write waits for wrap
// RULE3: Mode 2 sets compare A flag at top
// RULE4: Mode 2 toggle action inverts wave A
// RULE5: Pin shows wave only when direction output
// RULE6: Mode 2 overflow when count passes max
// RULE7: Modes 3, 7 fast; top max or A
// RULE8: Fast mode clears count tick after top
// RULE9: Fast: non-inverting clears on match, sets bottom
// RULE10: Fast mode overflow each time top reached
// RULE11: PWM toggle on A only with top-select
// RULE12: Fast mode compare values double buffered
// RULE13: Fast: A at bottom spikes, at max constant
// RULE14: Modes 1, 5 phase-correct; top max or A
// RULE15: Phase: up match clears, down match sets
// RULE16: Phase: reverse at top, hold one tick
// RULE17: Phase mode overflow at bottom
// RULE18: Phase: A bottom low, A max high
// RULE19: Phase: leaving max corrects level at bottom
// RULE20: Phase: missed up match corrected at bottom
// RULE21: Tick is clock over 1,8,64,256,1024
// RULE22: Match flag set next tick, cleared by write
// RULE23: PWM writes buffered, loaded at top
// RULE24: Reset clears waves; action zero does nothing
// RULE25: All updates only on timer tick; compare writes and flag clears here take effect on any clock
`timescale 1ns/1ps
module tmw_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input tmw_pkg::tmw_cfg_t cfg,
  // Compare register writes
  input wire logic compare_a_wr,
  input wire logic compare_b_wr,
  input wire logic [7:0] compare_wr_data,
  // Flag clears: write-one and interrupt service
  input tmw_pkg::tmw_flags_t flag_clear,
  input tmw_pkg::tmw_flags_t flag_ack,
  // Port pin settings per channel, index 0 is A
  input wire logic [1:0] dir_out,
  input wire logic [1:0] port_data,
  // Status
  output logic [7:0] count_value,
  output logic [7:0] compare_a_value,
  output logic [7:0] compare_b_value,
  output tmw_pkg::tmw_flags_t flags,
  // Waveform bits and pins
  output logic wave_out_a,
  output logic wave_out_b,
  output tmw_pkg::tmw_pin_t pin_a,
  output tmw_pkg::tmw_pin_t pin_b
);
  import tmw_pkg::*;

  logic tick;
  tmw_dir_t dir;
  logic [7:0] act_cmp [2];
  logic [7:0] buf_cmp [2];
  logic [1:0] wave;
  logic [1:0] up_hit;
  logic [1:0] match;
  logic [1:0] wr;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic fast;
  logic phase;
  logic clear_on_match_mode;
  logic pwm;
  logic ovf_ev;
  logic load;

  // Mode decoding
  function automatic logic is_fast(input logic [2:0] m);
    return m == TMW_MODE_FAST_FF || m == TMW_MODE_FAST_A;
  endfunction

  function automatic logic is_phase(input logic [2:0] m);
    return m == TMW_MODE_PC_FF || m == TMW_MODE_PC_A;
  endfunction

  function automatic logic top_from_a(input logic [2:0] m);
    return m == TMW_MODE_CTC || m == TMW_MODE_FAST_A || m == TMW_MODE_PC_A;
  endfunction

  // Tick source
  tmw_prescale u_pre
  (
    .clk(clk),
    .rst(rst),
    .clk_sel(cfg.clk_sel),
    .tick(tick)
  );

  // Mode and position decode
  assign fast = is_fast(cfg.wave_mode_sel);
  assign phase = is_phase(cfg.wave_mode_sel);
  assign clear_on_match_mode = cfg.wave_mode_sel == TMW_MODE_CTC;
  assign pwm = fast | phase;
  assign top = top_from_a(cfg.wave_mode_sel) ? act_cmp[0] : TMW_MAX; // RULE7 RULE14
  assign at_top = count_value == top;
  assign at_bottom = count_value == TMW_BOTTOM;
  assign wr = {compare_b_wr, compare_a_wr};

  // Overflow event per mode
  always_comb
  begin
    if (fast)
      ovf_ev = at_top; // RULE10
    else if (phase)
      ovf_ev = at_bottom && dir == TMW_DIR_DOWN; // RULE17
    else
      ovf_ev = count_value == TMW_MAX; // RULE6
  end

  // Buffer transfer point: leaving top in fast, at top in phase-correct
  assign load = tick && at_top && (fast || (phase && dir == TMW_DIR_UP)); // RULE23

  // Counter and direction
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_value <= TMW_COUNT_RST;
      dir <= TMW_DIR_UP;
    end
    else if (tick) // RULE25
    begin
      if (clear_on_match_mode)
      begin
        dir <= TMW_DIR_UP;
        count_value <= match[0] ? TMW_BOTTOM : count_value + 8'h01; // RULE1 RULE2
      end
      else if (fast)
      begin
        dir <= TMW_DIR_UP;
        count_value <= at_top ? TMW_BOTTOM : count_value + 8'h01; // RULE8
      end
      else if (phase)
      begin
        if (dir == TMW_DIR_UP && at_top)
        begin
          dir <= TMW_DIR_DOWN; // RULE16
          count_value <= count_value - 8'h01;
        end
        else if (dir == TMW_DIR_DOWN && at_bottom)
        begin
          dir <= TMW_DIR_UP;
          count_value <= count_value + 8'h01;
        end
        else if (dir == TMW_DIR_UP)
          count_value <= count_value + 8'h01;
        else
          count_value <= count_value - 8'h01;
      end
      else
      begin
        dir <= TMW_DIR_UP;
        count_value <= count_value + 8'h01;
      end
    end
  end

  // Sticky flags in one process, set wins over clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flags <= '0;
    else
    begin
      if (tick && ovf_ev)
        flags.overflow_flag <= 1'b1;
      else if (flag_clear.overflow_flag || flag_ack.overflow_flag)
        flags.overflow_flag <= 1'b0;
      if (tick && match[0])
        flags.compare_a_flag <= 1'b1; // RULE3 RULE22
      else if (flag_clear.compare_a_flag || flag_ack.compare_a_flag)
        flags.compare_a_flag <= 1'b0; // RULE22
      if (tick && match[1])
        flags.compare_b_flag <= 1'b1; // RULE22
      else if (flag_clear.compare_b_flag || flag_ack.compare_b_flag)
        flags.compare_b_flag <= 1'b0;
    end
  end

  // Readback of the values software wrote
  assign compare_a_value = buf_cmp[0];
  assign compare_b_value = buf_cmp[1];

  // Per channel compare, buffer and waveform logic
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    logic [1:0] act;
    logic tog_ok;

    assign act = (ch == 0) ? cfg.out_action_a : cfg.out_action_b;
    // Toggle in PWM only on channel A with top-select
    assign tog_ok = pwm ? (ch == 0 && cfg.wave_mode_sel[TMW_MODE_TOP_SEL_BIT]) : 1'b1; // RULE11
    assign match[ch] = count_value == act_cmp[ch];

    // Buffer and active compare value
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        buf_cmp[ch] <= TMW_COMPARE_RST;
        act_cmp[ch] <= TMW_COMPARE_RST;
      end
      else
      begin
        if (wr[ch])
          buf_cmp[ch] <= compare_wr_data;
        if (!pwm && wr[ch])
          act_cmp[ch] <= compare_wr_data; // RULE2
        else if (pwm && load)
          act_cmp[ch] <= buf_cmp[ch]; // RULE12 RULE23
      end
    end

    // Up-slope match seen since last bottom
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        up_hit[ch] <= 1'b0;
      else if (tick && phase)
      begin
        if (at_bottom && dir == TMW_DIR_DOWN)
          up_hit[ch] <= 1'b0;
        else if (match[ch] && dir == TMW_DIR_UP && !at_top)
          up_hit[ch] <= 1'b1;
      end
    end

    // Waveform bit
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        wave[ch] <= 1'b0; // RULE24
      else if (tick && act != TMW_ACT_OFF) // RULE24 RULE25
      begin
        if (fast && act[1])
        begin
          if (at_top)
            wave[ch] <= ~act[0]; // RULE9 RULE13
          else if (match[ch])
            wave[ch] <= act[0]; // RULE9
        end
        else if (phase && act[1])
        begin
          if (at_bottom && dir == TMW_DIR_DOWN)
          begin
            if (act_cmp[ch] == TMW_BOTTOM || (!up_hit[ch] && act_cmp[ch] != top))
              wave[ch] <= act[0]; // RULE18 RULE19 RULE20
          end
          else if (match[ch] && act_cmp[ch] == top)
            wave[ch] <= ~act[0]; // RULE18
          else if (match[ch])
            wave[ch] <= (dir == TMW_DIR_UP) ? act[0] : ~act[0]; // RULE15
        end
        else if (match[ch])
        begin
          case (act)
            TMW_ACT_TOGGLE: wave[ch] <= tog_ok ? ~wave[ch] : wave[ch]; // RULE4 RULE11
            TMW_ACT_CLEAR: wave[ch] <= 1'b0;
            TMW_ACT_SET: wave[ch] <= 1'b1;
            default: wave[ch] <= wave[ch];
          endcase
        end
      end
    end
  end

  // Waveform bits to the outside
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end
    else
    begin
      wave_out_a <= wave[0];
      wave_out_b <= wave[1];
    end
  end

  // Pin override and drive enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_a <= '0;
      pin_b <= '0;
    end
    else
    begin
      pin_a.out <= (cfg.out_action_a != TMW_ACT_OFF) ? wave[0] : port_data[0];
      pin_a.oe <= dir_out[0]; // RULE5
      pin_b.out <= (cfg.out_action_b != TMW_ACT_OFF) ? wave[1] : port_data[1];
      pin_b.oe <= dir_out[1]; // RULE5
    end
  end

  // Checks
  ctc_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    tick && clear_on_match_mode && match[0] |=> count_value == TMW_BOTTOM)
    else $error("count not cleared on compare A match");

  ctc_wrap_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    tick && clear_on_match_mode && !match[0] && count_value == TMW_MAX |=> count_value == TMW_BOTTOM)
    else $error("count did not wrap after max");

  ctc_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    tick && match[0] |=> flags.compare_a_flag)
    else $error("compare A flag not set on match");

  ctc_toggle_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    tick && clear_on_match_mode && match[0] && cfg.out_action_a == TMW_ACT_TOGGLE |=> wave[0] != $past(wave[0]))
    else $error("wave A did not toggle");

  pin_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    !dir_out[0] |=> !pin_a.oe)
    else $error("pin A driven while direction is input");

  ctc_ovf_a: assert property (@(posedge clk) disable iff (rst) // RULE6
    tick && clear_on_match_mode && count_value == TMW_MAX |=> flags.overflow_flag && count_value == TMW_BOTTOM)
    else $error("overflow flag missing at wrap");

  fast_restart_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    tick && fast && at_top |=> count_value == TMW_BOTTOM ##0 flags.overflow_flag)
    else $error("fast mode did not restart at bottom");

  fast_bottom_a: assert property (@(posedge clk) disable iff (rst) // RULE9
    tick && fast && at_top && cfg.out_action_a[1] |=> wave[0] == ~$past(cfg.out_action_a[0]))
    else $error("fast mode bottom level wrong");

  phase_turn_a: assert property (@(posedge clk) disable iff (rst) // RULE16
    tick && phase && at_top && dir == TMW_DIR_UP |=> dir == TMW_DIR_DOWN && count_value != $past(count_value))
    else $error("phase mode did not turn at top");

  phase_ovf_a: assert property (@(posedge clk) disable iff (rst) // RULE17
    tick && phase && at_bottom && dir == TMW_DIR_DOWN |=> flags.overflow_flag && dir == TMW_DIR_UP)
    else $error("phase mode overflow missing at bottom");

  buf_hold_a: assert property (@(posedge clk) disable iff (rst) // RULE23
    pwm && !load && $stable(cfg.wave_mode_sel) |=> act_cmp[0] == $past(act_cmp[0]))
    else $error("active compare changed outside top");

  tick_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE25
    !tick |=> $stable(count_value) && $stable(wave))
    else $error("timer state moved without tick");

  cov_ctc_c: cover property (@(posedge clk) disable iff (rst) tick && clear_on_match_mode && match[0]);
  cov_fast_c: cover property (@(posedge clk) disable iff (rst) tick && fast && at_top && cfg.out_action_a[1]);
  cov_phase_c: cover property (@(posedge clk) disable iff (rst) tick && phase && at_top && dir == TMW_DIR_UP);
  cov_fix_c: cover property (@(posedge clk) disable iff (rst) tick && phase && at_bottom && !up_hit[0]);

endmodule
